// ===== rxsc_pkg.sv
`default_nettype none

package rxsc_pkg;

  // ************************************************************
  // frame length limits, in bytes
  // ************************************************************
  localparam int LEN_W = 14;
  localparam logic [13:0] MAX_FRAME_LEN = 14'h05EE;
  localparam logic [13:0] MAX_LENGTH_FIELD = 14'h05DC;
  localparam logic [13:0] MIN_TYPE_LEN = 14'h000E;
  localparam logic [13:0] COLLISION_WINDOW = 14'h0040;
  localparam logic [13:0] WDOG_LEN = 14'h0800;
  localparam logic [13:0] WDOG_MAX_LEN = 14'h0A00;
  localparam logic [13:0] ADDR_BYTES = 14'h0006;
  localparam logic [13:0] TYPE_HI_IDX = 14'h000C;
  localparam logic [13:0] TYPE_LO_IDX = 14'h000D;
  localparam logic [2:0] DRIBBLE_MII = 3'h4;
  localparam logic [2:0] DRIBBLE_10M = 3'h3;

  // ************************************************************
  // status word layout
  // ************************************************************
  localparam int STAT_FILTER_FAIL = 30;
  localparam int STAT_LEN_LO = 16;
  localparam int STAT_ERROR_SUMMARY = 15;
  localparam int STAT_BROADCAST = 13;
  localparam int STAT_RUNT = 11;
  localparam int STAT_MULTICAST = 10;
  localparam int STAT_TOO_LONG = 7;
  localparam int STAT_COLLISION = 6;
  localparam int STAT_FRAME_TYPE = 5;
  localparam int STAT_WATCHDOG = 4;
  localparam int STAT_MII_ERROR = 3;
  localparam int STAT_DRIBBLE = 2;
  localparam int STAT_CRC_ERROR = 1;

  // ************************************************************
  // host register map
  // ************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RX_STATUS = 8'h08;
  localparam logic [7:0] REG_RX_DATA = 8'h0C;
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_FLUSH = 1;
  localparam int CTRL_ERR_CLEAR = 2;
  localparam logic ENABLE_RESET = 1'h0;

endpackage : rxsc_pkg

`default_nettype wire

// ===== rxsc_if.sv
`timescale 1ns/100ps
`default_nettype none

interface rxsc_if;
  logic receive_enable;
  logic stat_pop;
  logic data_pop;
  logic flush;
  logic err_clr;
  logic receiver_halted_pulse;
  logic stat_valid;
  logic [31:0] stat_word;
  logic data_valid;
  logic [7:0] data_byte;
  logic receiver_error_flag;

  modport device (
    input receive_enable, stat_pop, data_pop, flush, err_clr,
    output receiver_halted_pulse, stat_valid, stat_word,
    output data_valid, data_byte, receiver_error_flag
  );
  modport host (
    output receive_enable, stat_pop, data_pop, flush, err_clr,
    input receiver_halted_pulse, stat_valid, stat_word,
    input data_valid, data_byte, receiver_error_flag
  );
endinterface : rxsc_if

`default_nettype wire

// ===== rxsc_device.sv
// How it works
// - too-long bit 7 above 1518 bytes
// - too-long never truncates the frame
// - bit 6 marks a late collision
// - bit 5 set when type field exceeds 1500
// - frame type stays clear under 14 bytes
// - bit 4 set past 2048 bytes, watchdog
// - bit 3 set when RX_ER seen in frame
// - bit 2 for dribble, 4 MII, 3+ 10M
// - dribble suppressed by collision; frame still valid
// - bit 1 on bad CRC or RX_ER
// - host ignores CRC for runt, collision, watchdog
// - bit 0 always reads zero
// - host clears receive enable to stop
// - one halted pulse once receiver stops
// - host may flush, then re-enables receiver
// - receiver keeps running on receiver error
// - error on underruns or status overrun
// - host resolves receiver errors itself
// - error summary ORs bits 11, 7, 6, 1
// - length in 29:16, filter fail bit 30
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

// ************************************************************
// show-ahead fifo with registered head
// ************************************************************
module rxsc_fifo #(
  parameter int W = 8,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic flush,
  input wire logic push,
  input wire logic [W-1:0] din,
  input wire logic pop,
  output logic valid,
  output logic [W-1:0] dout,
  output logic full
);
  localparam logic [AW:0] DEPTH = (AW+1)'(1 << AW);
  logic [W-1:0] mem [0:(1<<AW)-1];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire pop_ok = pop && (count != '0);
  wire push_ok = push && (count != DEPTH);
  wire [AW-1:0] next_rd_ptr = rd_ptr + AW'(pop_ok);
  wire [AW:0] next_count = count + (AW+1)'(push_ok) - (AW+1)'(pop_ok);
  // a word written this edge into the new head slot is bypassed
  wire [W-1:0] next_dout =
    (push_ok && wr_ptr == next_rd_ptr) ? din : mem[next_rd_ptr];

  assign full = (count == DEPTH);

  always_ff @(posedge clk) begin
    if (push_ok) begin
      mem[wr_ptr] <= din;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      valid <= 1'h0;
      dout <= '0;
    end else begin
      wr_ptr <= wr_ptr + AW'(push_ok);
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      valid <= (next_count != '0);
      dout <= next_dout;
    end
  end
endmodule : rxsc_fifo

// ************************************************************
// receive status and control, device end
// ************************************************************
module rxsc_device #(
  parameter int STAT_AW = 4,
  parameter int DATA_AW = 11
) (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic RX_DV,
  input wire logic RX_STB,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_ER,
  input wire logic RX_COL,
  input wire logic [2:0] RX_DRIBBLE,
  input wire logic RX_CRC_OK,
  input wire logic RX_FILTER_FAIL,
  input wire logic RX_MODE_10M,
  rxsc_if.device link
);
  typedef enum logic [1:0] {
    RXSC_IDLE, RXSC_FRAME, RXSC_SKIP, RXSC_HALTED
  } rxsc_state_t;

  rxsc_state_t state;
  rxsc_state_t next_state;
  logic dv_q;
  logic [13:0] byte_cnt;
  logic seen_er;
  logic seen_col;
  logic is_bcast;
  logic is_mcast;
  logic [7:0] type_hi;
  logic [7:0] type_lo;
  logic halted_pulse;
  logic err_flag;

  // ************************************************************
  // frame tracking
  // ************************************************************
  // a frame is only taken from its first cycle, never mid-stream
  wire start = (state == RXSC_IDLE) && link.receive_enable &&
               RX_DV && !dv_q;
  wire in_frame = (state == RXSC_FRAME) || start;
  wire frame_end = (state == RXSC_FRAME) && !RX_DV;
  wire byte_take = in_frame && RX_DV && RX_STB;
  wire [13:0] base_cnt = start ? '0 : byte_cnt;
  // bytes past the 2560-byte watchdog maximum are dropped, earlier ones kept
  wire store = byte_take && (base_cnt < rxsc_pkg::WDOG_MAX_LEN);
  wire base_er = start ? 1'h0 : seen_er;
  wire base_col = start ? 1'h0 : seen_col;
  wire base_bcast = start ? 1'h1 : is_bcast;
  wire late_col = in_frame && RX_COL &&
                  (base_cnt >= rxsc_pkg::COLLISION_WINDOW);

  always_comb begin
    next_state = state;
    case (state)
      RXSC_IDLE: begin
        if (!link.receive_enable) begin
          next_state = RXSC_HALTED;
        end else if (start) begin
          next_state = RXSC_FRAME;
        end
      end
      RXSC_FRAME: begin
        if (frame_end) begin
          next_state = link.receive_enable ? RXSC_IDLE : RXSC_HALTED;
        end
      end
      RXSC_SKIP: begin
        if (!RX_DV) begin
          next_state = RXSC_IDLE;
        end
      end
      default: begin
        if (link.receive_enable) begin
          next_state = RX_DV ? RXSC_SKIP : RXSC_IDLE;
        end
      end
    endcase
  end

  // the pulse fires on entering halt, from idle or once a frame closes
  wire next_halted_pulse = (next_state == RXSC_HALTED) &&
                           (state != RXSC_HALTED);

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      state <= RXSC_HALTED;
      dv_q <= 1'h0;
      halted_pulse <= 1'h0;
    end else begin
      state <= next_state;
      dv_q <= RX_DV;
      halted_pulse <= next_halted_pulse;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      byte_cnt <= '0;
      seen_er <= 1'h0;
      seen_col <= 1'h0;
      is_bcast <= 1'h0;
      is_mcast <= 1'h0;
      type_hi <= 8'h00;
      type_lo <= 8'h00;
    end else if (in_frame) begin
      byte_cnt <= base_cnt + 14'(store);
      seen_er <= base_er || RX_ER;
      seen_col <= base_col || late_col;
      is_bcast <= base_bcast && !(byte_take &&
        base_cnt < rxsc_pkg::ADDR_BYTES && RX_DATA != 8'hFF);
      if (byte_take && base_cnt == '0) begin
        is_mcast <= RX_DATA[0];
      end else if (start) begin
        is_mcast <= 1'h0;
      end
      if (byte_take && base_cnt == rxsc_pkg::TYPE_HI_IDX) begin
        type_hi <= RX_DATA;
      end
      if (byte_take && base_cnt == rxsc_pkg::TYPE_LO_IDX) begin
        type_lo <= RX_DATA;
      end
    end
  end

  // ************************************************************
  // status word
  // ************************************************************
  wire runt = byte_cnt < rxsc_pkg::COLLISION_WINDOW;
  wire too_long = byte_cnt > rxsc_pkg::MAX_FRAME_LEN;
  wire [15:0] type_field = {type_hi, type_lo};
  wire frame_type = (byte_cnt >= rxsc_pkg::MIN_TYPE_LEN) &&
                    (type_field > {2'h0, rxsc_pkg::MAX_LENGTH_FIELD});
  wire watchdog = byte_cnt > rxsc_pkg::WDOG_LEN;
  wire dribble_len = RX_MODE_10M ? (RX_DRIBBLE >= rxsc_pkg::DRIBBLE_10M)
                                 : (RX_DRIBBLE == rxsc_pkg::DRIBBLE_MII);
  wire dribble = dribble_len && !seen_col;
  wire crc_error = !RX_CRC_OK || seen_er;
  wire error_summary = runt || too_long || seen_col || crc_error;
  wire all_ones = is_bcast && (byte_cnt >= rxsc_pkg::ADDR_BYTES);

  logic [31:0] frame_status;
  always_comb begin
    frame_status = 32'h0000_0000;
    frame_status[rxsc_pkg::STAT_FILTER_FAIL] = RX_FILTER_FAIL;
    frame_status[rxsc_pkg::STAT_LEN_LO +: rxsc_pkg::LEN_W] = byte_cnt;
    frame_status[rxsc_pkg::STAT_ERROR_SUMMARY] = error_summary;
    frame_status[rxsc_pkg::STAT_BROADCAST] = all_ones;
    frame_status[rxsc_pkg::STAT_RUNT] = runt;
    frame_status[rxsc_pkg::STAT_MULTICAST] = is_mcast && !all_ones;
    frame_status[rxsc_pkg::STAT_TOO_LONG] = too_long;
    frame_status[rxsc_pkg::STAT_COLLISION] = seen_col;
    frame_status[rxsc_pkg::STAT_FRAME_TYPE] = frame_type;
    frame_status[rxsc_pkg::STAT_WATCHDOG] = watchdog;
    frame_status[rxsc_pkg::STAT_MII_ERROR] = seen_er;
    frame_status[rxsc_pkg::STAT_DRIBBLE] = dribble;
    frame_status[rxsc_pkg::STAT_CRC_ERROR] = crc_error;
  end

  // ************************************************************
  // fifos and receiver error
  // ************************************************************
  wire stat_full;
  wire stat_overrun = frame_end && stat_full;
  wire stat_underrun = link.stat_pop && !link.stat_valid;
  wire data_underrun = link.data_pop && !link.data_valid;
  // set wins over the host clear; reception is never stopped by it
  wire next_err_flag = stat_overrun || stat_underrun || data_underrun ||
                       (err_flag && !link.err_clr);

  rxsc_fifo #(.W(32), .AW(STAT_AW)) stat_fifo (
    .clk(CLK_SYS),
    .srst(SRST),
    .flush(link.flush),
    .push(frame_end),
    .din(frame_status),
    .pop(link.stat_pop),
    .valid(link.stat_valid),
    .dout(link.stat_word),
    .full(stat_full)
  );

  // overflowing data bytes are dropped; the status word still tells
  rxsc_fifo #(.W(8), .AW(DATA_AW)) data_fifo (
    .clk(CLK_SYS),
    .srst(SRST),
    .flush(link.flush),
    .push(store),
    .din(RX_DATA),
    .pop(link.data_pop),
    .valid(link.data_valid),
    .dout(link.data_byte),
    .full()
  );

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      err_flag <= 1'h0;
    end else begin
      err_flag <= next_err_flag;
    end
  end

  assign link.receiver_error_flag = err_flag;
  assign link.receiver_halted_pulse = halted_pulse;
endmodule : rxsc_device

`default_nettype wire

// ===== rxsc_host.sv
`timescale 1ns/100ps
`default_nettype none

// ************************************************************
// receive controller, host end
// ************************************************************
module rxsc_host (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  rxsc_if.host link
);
  logic enable;
  logic halted;
  logic flush;
  logic err_clr;

  wire wr_ctrl = WR && (ADDR == rxsc_pkg::REG_CTRL);
  wire rd_rx_status = RD && (ADDR == rxsc_pkg::REG_RX_STATUS);
  wire rd_rx_data = RD && (ADDR == rxsc_pkg::REG_RX_DATA);
  wire next_enable = wr_ctrl ? WDATA[rxsc_pkg::CTRL_ENABLE] : enable;
  // flushing is only honoured while the receiver is stopped
  wire next_flush = wr_ctrl && WDATA[rxsc_pkg::CTRL_FLUSH] &&
                    halted && !enable;
  wire next_err_clr = wr_ctrl && WDATA[rxsc_pkg::CTRL_ERR_CLEAR];
  // halt is sticky until software restarts; a new pulse wins
  wire next_halted = link.receiver_halted_pulse ||
                     (halted && !(wr_ctrl && WDATA[rxsc_pkg::CTRL_ENABLE]));

  wire [31:0] status_view = {28'h000_0000, link.data_valid,
                             link.stat_valid, link.receiver_error_flag,
                             halted};
  wire [31:0] ctrl_view = {31'h0000_0000, enable};
  wire [31:0] next_rdata =
    !RD ? 32'h0000_0000 :
    (ADDR == rxsc_pkg::REG_CTRL) ? ctrl_view :
    (ADDR == rxsc_pkg::REG_STATUS) ? status_view :
    rd_rx_status ? link.stat_word :
    rd_rx_data ? {24'h00_0000, link.data_byte} :
    32'h0000_0000;

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      enable <= rxsc_pkg::ENABLE_RESET;
      halted <= 1'h0;
      flush <= 1'h0;
      err_clr <= 1'h0;
      RDATA <= 32'h0000_0000;
    end else begin
      enable <= next_enable;
      halted <= next_halted;
      flush <= next_flush;
      err_clr <= next_err_clr;
      RDATA <= next_rdata;
    end
  end

  // pops follow the read strobe so back-to-back reads see fresh heads
  assign link.stat_pop = rd_rx_status;
  assign link.data_pop = rd_rx_data;
  assign link.receive_enable = enable;
  assign link.flush = flush;
  assign link.err_clr = err_clr;
endmodule : rxsc_host

`default_nettype wire

// ===== rxsc_assertions.sv
`timescale 1ns/100ps
`default_nettype none

module rxsc_assertions (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic receive_enable,
  input wire logic stat_pop,
  input wire logic data_pop,
  input wire logic err_clr,
  input wire logic receiver_halted_pulse,
  input wire logic stat_valid,
  input wire logic [31:0] stat_word,
  input wire logic data_valid,
  input wire logic receiver_error_flag
);
  // ************************************************************
  // status word, halt and error flag checks
  // ************************************************************
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  wire logic [13:0] len = stat_word[29:16];
  sequence s_word;
    stat_valid;
  endsequence
  sequence s_halt;
    $rose(receiver_halted_pulse);
  endsequence

  bit_zero_a: assert property (s_word |-> !stat_word[0])
    else $error("reserved status bit set");
  err_summary_a: assert property (s_word |-> stat_word[15] ==
    |{stat_word[11], stat_word[7], stat_word[6], stat_word[1]})
    else $error("error summary mismatch");
  too_long_a: assert property (s_word |->
    stat_word[7] == (len > rxsc_pkg::MAX_FRAME_LEN))
    else $error("too long bit mismatch");
  watchdog_bit_a: assert property (s_word |->
    stat_word[4] == (len > rxsc_pkg::WDOG_LEN))
    else $error("watchdog bit mismatch");
  runt_type_a: assert property (
    s_word and len < rxsc_pkg::MIN_TYPE_LEN |-> !stat_word[5])
    else $error("frame type set on short frame");
  dribble_col_a: assert property (
    s_word and stat_word[6] |-> !stat_word[2])
    else $error("dribble not suppressed");
  mii_crc_a: assert property (s_word and stat_word[3] |-> stat_word[1])
    else $error("receive error without crc bit");
  halt_pulse_a: assert property (
    s_halt |=> !receiver_halted_pulse [*2])
    else $error("halted pulse too long");
  halt_off_a: assert property (
    receiver_halted_pulse |-> !receive_enable)
    else $error("halted pulse while enabled");
  err_sticky_a: assert property (
    receiver_error_flag && !err_clr |=> receiver_error_flag)
    else $error("error flag dropped");
  underrun_flag_a: assert property ((stat_pop && !stat_valid) ||
    (data_pop && !data_valid) |=> receiver_error_flag)
    else $error("underrun not flagged");
endmodule : rxsc_assertions

`default_nettype wire

// ===== rxsc_tb.sv
`timescale 1ns/100ps
`default_nettype none

module rxsc_tb;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic CLK_SYS, SRST, RX_DV, RX_STB, RX_ER, RX_COL, RX_CRC_OK;
  logic RX_FILTER_FAIL, RX_MODE_10M, WR, RD, rd_d;
  logic [7:0] RX_DATA, ADDR;
  logic [2:0] RX_DRIBBLE;
  logic [31:0] WDATA, RDATA;
  logic [31:0] exp_q[$], msk_q[$];
  localparam int DATA_DEPTH = 2048;
  logic [7:0] hdr[0:DATA_DEPTH-1];
  int failures = 0, checks_done = 0, pulses = 0;
  bit hold_frame = 1'b0;

  rxsc_if link();
  rxsc_device u_rxsc_device (.CLK_SYS(CLK_SYS), .SRST(SRST), .RX_DV(RX_DV),
    .RX_STB(RX_STB), .RX_DATA(RX_DATA), .RX_ER(RX_ER), .RX_COL(RX_COL),
    .RX_DRIBBLE(RX_DRIBBLE), .RX_CRC_OK(RX_CRC_OK), .link(link),
    .RX_FILTER_FAIL(RX_FILTER_FAIL), .RX_MODE_10M(RX_MODE_10M));
  rxsc_host u_rxsc_host (.CLK_SYS(CLK_SYS), .SRST(SRST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .link(link));
  rxsc_assertions u_rxsc_assertions (.CLK_SYS(CLK_SYS), .SRST(SRST),
    .receive_enable(link.receive_enable), .stat_pop(link.stat_pop),
    .data_pop(link.data_pop), .err_clr(link.err_clr),
    .receiver_halted_pulse(link.receiver_halted_pulse),
    .stat_valid(link.stat_valid), .stat_word(link.stat_word),
    .data_valid(link.data_valid),
    .receiver_error_flag(link.receiver_error_flag));

  initial begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end

  // ************************************************************
  // host bus and frame drivers
  // ************************************************************
  task automatic chk(input logic [31:0] got, exp, msk);
    checks_done++;
    if ((got & msk) !== (exp & msk)) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK_SYS);
    WR <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    @(posedge CLK_SYS);
    ADDR <= a;
    RD <= 1'b1;
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge CLK_SYS);
    RD <= 1'b0;
  endtask : rd

  // the read data stands only in the cycle after the strobe
  always @(posedge CLK_SYS) begin
    rd_d <= RD;
    if (link.receiver_halted_pulse === 1'b1) pulses++;
    if (rd_d === 1'b1) begin
      chk(RDATA, exp_q.pop_front(), msk_q.pop_front());
    end
  end

  task automatic frame(input int n, input logic [15:0] typ,
      input logic er, col, crc, m10, filt, input logic [2:0] drib);
    int len;
    int k;
    logic [7:0] b;
    logic [31:0] s;
    logic [31:0] m;
    // collision is raised at byte 70, so short frames never see one
    col = col && n > 70;
    len = (n > rxsc_pkg::WDOG_MAX_LEN) ? rxsc_pkg::WDOG_MAX_LEN : n;
    @(posedge CLK_SYS);
    RX_CRC_OK <= crc;
    RX_MODE_10M <= m10;
    RX_FILTER_FAIL <= filt;
    RX_DRIBBLE <= drib;
    for (int i = 0; i < n; i++) begin
      @(posedge CLK_SYS);
      b = (i == 12) ? typ[15:8] : (i == 13) ? typ[7:0] : 8'($urandom);
      if (i == 0) b = 8'h02;
      if (i < DATA_DEPTH) hdr[i] = b;
      RX_DATA <= b;
      RX_DV <= 1'b1;
      RX_STB <= 1'b1;
      RX_ER <= er && (i == n / 2);
      RX_COL <= col && (i == 70);
    end
    @(posedge CLK_SYS);
    RX_DV <= 1'b0;
    RX_STB <= 1'b0;
    RX_ER <= 1'b0;
    RX_COL <= 1'b0;
    s = {1'b0, filt, 14'(len), 16'h0000};
    s[11] = len < rxsc_pkg::COLLISION_WINDOW;
    s[7] = len > rxsc_pkg::MAX_FRAME_LEN;
    s[6] = col;
    s[5] = typ > rxsc_pkg::MAX_LENGTH_FIELD && len >= 14;
    s[4] = len > rxsc_pkg::WDOG_LEN;
    s[3] = er;
    s[2] = !col && (m10 ? drib >= rxsc_pkg::DRIBBLE_10M :
      drib == rxsc_pkg::DRIBBLE_MII);
    s[1] = !crc || er;
    s[15] = s[11] | s[7] | s[6] | s[1];
    m = ALL;
    if (s[11] || s[6] || s[4]) m[1] = 1'b0;
    repeat (2) @(posedge CLK_SYS);
    // a held frame stays queued so that a flush has something to empty
    if (!hold_frame) begin
      rd(8'h08, s, m);
      for (k = 0; k < 2600; k++) begin
        @(negedge CLK_SYS);
        if (link.data_valid !== 1'b1) break;
        rd(8'h0C, 32'(hdr[k[10:0]]), 32'hFF);
      end
      // the data fifo keeps the first bytes and drops the overflow
      chk(k, (n > DATA_DEPTH) ? DATA_DEPTH : n, ALL);
    end
  endtask : frame

  task automatic end_of_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    SRST = 1'b1;
    {RX_DV, RX_STB, RX_ER, RX_COL, RX_FILTER_FAIL, RX_MODE_10M} = 6'h00;
    {WR, RD, RX_CRC_OK, RX_DRIBBLE, RX_DATA, ADDR} = 22'h0_0000;
    WDATA = 32'h0000_0000;
    void'($urandom(2579));
    repeat (6) @(posedge CLK_SYS);
    SRST <= 1'b0;
    rd(8'h04, 32'h0, 32'hE);
    rd(8'h08, 32'h0, 32'h0);
    rd(8'h10, 32'h0, ALL);
    wr(8'h00, 32'h1);
    rd(8'h04, 32'h2, ALL);
    frame(10, 16'h0800, 0, 0, 1, 0, 0, 3'h0);
    frame(60, 16'h0800, 1, 0, 1, 0, 1, 3'h0);
    frame(100, 16'h05DC, 0, 0, 1, 0, 0, 3'h4);
    frame(100, 16'h05DD, 0, 1, 1, 1, 0, 3'h3);
    frame(100, 16'h0600, 0, 0, 0, 0, 0, 3'h3);
    frame(100, 16'h0600, 0, 0, 1, 1, 0, 3'h2);
    frame(1518, 16'h0800, 0, 0, 1, 0, 0, 3'h0);
    frame(1519, 16'h0800, 0, 0, 1, 0, 0, 3'h0);
    frame(2048, 16'h0800, 0, 0, 1, 0, 0, 3'h0);
    frame(2049, 16'h0800, 0, 0, 1, 0, 0, 3'h0);
    frame(2600, 16'h0800, 0, 0, 1, 0, 0, 3'h0);
    wr(8'h00, 32'h5);
    rd(8'h04, 32'h0, 32'h2);
    for (int j = 0; j < 4; j++) begin
      frame(14 + $urandom % 200, 16'($urandom), 1'($urandom), 1'($urandom),
        1'($urandom), 1'($urandom), 1'($urandom), 3'($urandom));
    end
    hold_frame = 1'b1;
    fork
      frame(200, 16'h0800, 0, 0, 1, 0, 0, 3'h0);
      begin
        repeat (50) @(posedge CLK_SYS);
        wr(8'h00, 32'h0);
      end
    join
    hold_frame = 1'b0;
    // the held frame leaves both fifos non-empty for the flush below
    rd(8'h04, 32'hD, 32'hF);
    chk(pulses, 1, ALL);
    wr(8'h00, 32'h2);
    rd(8'h04, 32'h1, 32'hF);
    wr(8'h00, 32'h1);
    rd(8'h04, 32'h0, 32'h1);
    frame(64, 16'h0800, 0, 0, 1, 0, 0, 3'h0);
    repeat (2) @(posedge CLK_SYS);
    chk(exp_q.size(), 0, ALL);
    end_of_test();
  end

  initial begin
    repeat (90000) @(posedge CLK_SYS);
    failures++;
    end_of_test();
  end
endmodule : rxsc_tb

`default_nettype wire
